// file: design/smc_defs.vh
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH

// Request address: 64 MB window shared by memory and I/O banks.
`define SMC_ADDR_W        26
`define SMC_IO_SPACE_BIT  25
`define SMC_MEM_BANK_BIT  24
`define SMC_IO_BANK_HI    15
`define SMC_IO_BANK_LO    14
`define SMC_IO_BANK_NONE  2'h3

// Bank index into the timing store: 0..1 memory, 2..4 I/O.
`define SMC_BANK_IDX_W    3
`define SMC_BANK_COUNT    5
`define SMC_IO_IDX_BASE   3'h2

// Bank setting word: {wide, setup, strobe, hold}; each phase lasts field+1 cycles.
`define SMC_CFG_W         13
`define SMC_CFG_WIDE_BIT  12
`define SMC_CFG_SETUP_HI  11
`define SMC_CFG_SETUP_LO  8
`define SMC_CFG_STRB_HI   7
`define SMC_CFG_STRB_LO   4
`define SMC_CFG_HOLD_HI   3
`define SMC_CFG_HOLD_LO   0
`define SMC_CFG_RST       13'h0fff

`endif

// file: design/smc_cfg_mem.v
`timescale 1ns/100ps
`include "smc_defs.vh"

// Per-bank width and timing store with a registered read port.
module smc_cfg_mem #(
   parameter DEPTH  = `SMC_BANK_COUNT,
   parameter WIDTH  = `SMC_CFG_W,
   parameter ADDR_W = `SMC_BANK_IDX_W
) (
   input  wire              sys_clk_i,
   input  wire              sys_rst_i,
   input  wire              ce_i,
   input  wire              wr_en_i,
   input  wire [ADDR_W-1:0] wr_addr_i,
   input  wire [WIDTH-1:0]  wr_data_i,
   input  wire [ADDR_W-1:0] rd_addr_i,
   output reg  [WIDTH-1:0]  rd_data_o
);
   reg     [WIDTH-1:0] mem [0:DEPTH-1];
   integer             i;

   always @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] <= `SMC_CFG_RST;
         end
         rd_data_o <= `SMC_CFG_RST;
      end else if (ce_i) begin
         if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
         end
         rd_data_o <= mem[rd_addr_i];
      end
   end
endmodule

// file: design/smc_static_ctrl.v
// What this block does
// - Two memory banks each have a software-set 8 or 16 bit width and programmable setup, strobe and hold.
// - Three I/O banks each have a software-set 8 or 16 bit width and programmable setup, strobe and hold.
// - All five banks share one 64 MB request address window.
// - Memory banks shift the address by bank width so memory bit 0 and 1 always meet address lines 0 and 1.
// - A strap sampled at reset release sets the width of memory bank 0 so it can serve as boot bank.
// - The output enable pin is sampled at reset as watchdog polarity, 0 active high and 1 active low.
// - The shared output enable goes low to make the selected device drive read data.
// - Active-low byte write strobes write the addressed bytes.
// - The data bus is driven only during this block's own cycles, and an access never starts while the NAND side holds it.
// - A low external wait extends the strobe phase until it is released.
// - Only the addressed memory bank chip select goes low during its access.
// - Each I/O bank spans 16 KB and has its own active-low select.
// - The high strobe writes bits 15 to 8, the low strobe bits 7 to 0 or the whole 8-bit word.
`timescale 1ns/100ps
`include "smc_defs.vh"

module smc_static_ctrl #(
   parameter AW = `SMC_ADDR_W
) (
   input  wire                        sys_clk_i,
   input  wire                        sys_rst_i,
   input  wire                        ce_i,
   input  wire                        req_valid_i,
   input  wire                        req_write_i,
   input  wire                        req_half_i,
   input  wire [AW-1:0]               req_addr_i,
   input  wire [15:0]                 req_wdata_i,
   output reg                         req_ready_o,
   output reg                         resp_valid_o,
   output reg                         resp_error_o,
   output reg  [15:0]                 resp_rdata_o,
   input  wire                        cfg_write_i,
   input  wire [`SMC_BANK_IDX_W-1:0]  cfg_bank_i,
   input  wire [`SMC_CFG_W-1:0]       cfg_data_i,
   input  wire                        boot_wide_strap_i,
   input  wire                        nand_bus_busy_i,
   input  wire                        watchdog_reset_req_i,
   output reg                         watchdog_reset_out_o,
   output reg  [AW-1:0]               ext_addr_o,
   output reg  [1:0]                  memory_bank_select_n_o,
   output reg  [2:0]                  io_bank_select_n_o,
   input  wire                        static_output_enable_n_i,
   output reg                         static_output_enable_n_o,
   output reg                         static_output_enable_n_oe_o,
   output reg                         low_byte_write_strobe_n_o,
   output reg                         high_byte_write_strobe_n_o,
   input  wire                        external_wait_n_i,
   input  wire [15:0]                 static_data_bus_i,
   output reg  [15:0]                 static_data_bus_o,
   output reg                         static_data_bus_oe_o
);
   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_LOAD   = 3'h1;
   localparam [2:0] ST_SETUP  = 3'h2;
   localparam [2:0] ST_STROBE = 3'h3;
   localparam [2:0] ST_HOLD   = 3'h4;

   reg  [2:0]                  state;
   reg  [3:0]                  cnt;
   reg  [`SMC_BANK_IDX_W-1:0]  bank;
   reg                         is_io;
   reg                         wr;
   reg                         half;
   reg                         wide;
   reg                         beat;
   reg  [AW-1:0]               addr;
   reg  [15:0]                 wdata;
   reg  [3:0]                  strobe_len;
   reg  [3:0]                  hold_len;
   reg                         strap_done;
   reg                         wdt_active_low;
   reg                         boot_wide;
   reg                         bank0_written;
   wire [`SMC_CFG_W-1:0]       cfg_q;
   wire                        cfg_wide;
   wire [1:0]                  io_field;
   wire                        req_unmapped;
   wire [`SMC_BANK_IDX_W-1:0]  req_bank;
   wire [`SMC_BANK_IDX_W-1:0]  cfg_rd_bank;

   assign io_field = req_addr_i[`SMC_IO_BANK_HI:`SMC_IO_BANK_LO];
   assign req_unmapped = req_addr_i[`SMC_IO_SPACE_BIT] && io_field == `SMC_IO_BANK_NONE;
   assign req_bank     = req_addr_i[`SMC_IO_SPACE_BIT] ? `SMC_IO_IDX_BASE + {1'b0, io_field}
                                                       : {2'h0, req_addr_i[`SMC_MEM_BANK_BIT]};
   // The setting store answers one edge late, so while idle it is already addressed with the requested bank.
   assign cfg_rd_bank  = (state == ST_IDLE && !req_unmapped) ? req_bank : bank;
   // Until software sets bank 0, its width follows the boot strap.
   assign cfg_wide = (bank == 3'h0 && !bank0_written) ? boot_wide : cfg_q[`SMC_CFG_WIDE_BIT];

   smc_cfg_mem u_cfg (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .wr_en_i   (cfg_write_i),
      .wr_addr_i (cfg_bank_i),
      .wr_data_i (cfg_data_i),
      .rd_addr_i (cfg_rd_bank),
      .rd_data_o (cfg_q)
   );

   // Pin address for one beat.
   function [AW-1:0] pin_addr;
      input [AW-1:0] a;
      input          io;
      input          w;
      input          b;
      begin
         if (io) begin
            pin_addr = {a[AW-1:1], a[0] | b};
         end else if (w) begin
            pin_addr = {1'b0, a[AW-1:1]};
         end else begin
            pin_addr = {a[AW-1:1], a[0] | b};
         end
      end
   endfunction

   // Bus data for one write beat; an 8-bit device sees its byte on the low lane.
   function [15:0] beat_data;
      input [15:0] d;
      input        h;
      input        w;
      input        b;
      begin
         if (w && h) begin
            beat_data = d;
         end else if (w) begin
            beat_data = {d[7:0], d[7:0]};
         end else begin
            beat_data = {8'h00, b ? d[15:8] : d[7:0]};
         end
      end
   endfunction

   always @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state                       <= ST_IDLE;
         cnt                         <= 4'h0;
         bank                        <= 3'h0;
         is_io                       <= 1'b0;
         wr                          <= 1'b0;
         half                        <= 1'b0;
         wide                        <= 1'b0;
         beat                        <= 1'b0;
         addr                        <= {AW{1'b0}};
         wdata                       <= 16'h0000;
         strobe_len                  <= 4'h0;
         hold_len                    <= 4'h0;
         strap_done                  <= 1'b0;
         wdt_active_low              <= 1'b0;
         boot_wide                   <= 1'b0;
         bank0_written               <= 1'b0;
         req_ready_o                 <= 1'b0;
         resp_valid_o                <= 1'b0;
         resp_error_o                <= 1'b0;
         resp_rdata_o                <= 16'h0000;
         watchdog_reset_out_o        <= 1'b0;
         ext_addr_o                  <= {AW{1'b0}};
         memory_bank_select_n_o      <= 2'h3;
         io_bank_select_n_o          <= 3'h7;
         static_output_enable_n_o    <= 1'b1;
         static_output_enable_n_oe_o <= 1'b0;
         low_byte_write_strobe_n_o   <= 1'b1;
         high_byte_write_strobe_n_o  <= 1'b1;
         static_data_bus_o           <= 16'h0000;
         static_data_bus_oe_o        <= 1'b0;
      end else if (ce_i) begin
         // The enable pin floats through reset so its pull-down or a board strap can be read.
         if (!strap_done) begin
            wdt_active_low              <= static_output_enable_n_i;
            boot_wide                   <= boot_wide_strap_i;
            strap_done                  <= 1'b1;
            static_output_enable_n_oe_o <= 1'b1;
            req_ready_o                 <= 1'b1;
         end
         watchdog_reset_out_o <= watchdog_reset_req_i ^ wdt_active_low;
         if (cfg_write_i && cfg_bank_i == 3'h0) begin
            bank0_written <= 1'b1;
         end
         resp_valid_o <= 1'b0;
         case (state)
            ST_IDLE: begin
               // Hold off while the NAND side owns the shared bus.
               if (strap_done && req_ready_o && req_valid_i && !nand_bus_busy_i) begin
                  is_io <= req_addr_i[`SMC_IO_SPACE_BIT];
                  wr    <= req_write_i;
                  half  <= req_half_i;
                  addr  <= req_addr_i;
                  wdata <= req_wdata_i;
                  beat  <= 1'b0;
                  if (req_unmapped) begin
                     resp_valid_o <= 1'b1;
                     resp_error_o <= 1'b1;
                     resp_rdata_o <= 16'h0000;
                  end else begin
                     bank        <= req_bank;
                     req_ready_o <= 1'b0;
                     state       <= ST_LOAD;
                  end
               end
            end
            ST_LOAD: begin
               wide       <= cfg_wide;
               strobe_len <= cfg_q[`SMC_CFG_STRB_HI:`SMC_CFG_STRB_LO];
               hold_len   <= cfg_q[`SMC_CFG_HOLD_HI:`SMC_CFG_HOLD_LO];
               cnt        <= cfg_q[`SMC_CFG_SETUP_HI:`SMC_CFG_SETUP_LO];
               ext_addr_o <= pin_addr(addr, is_io, cfg_wide, beat);
               if (is_io) begin
                  io_bank_select_n_o <= ~(3'h1 << (bank - `SMC_IO_IDX_BASE));
               end else begin
                  memory_bank_select_n_o <= ~(2'h1 << bank[0]);
               end
               static_data_bus_o    <= beat_data(wdata, half, cfg_wide, beat);
               static_data_bus_oe_o <= wr;
               state                <= ST_SETUP;
            end
            ST_SETUP: begin
               if (cnt == 4'h0) begin
                  cnt <= strobe_len;
                  if (wr) begin
                     if (!wide) begin
                        low_byte_write_strobe_n_o <= 1'b0;
                     end else begin
                        low_byte_write_strobe_n_o  <= ~(half | ~addr[0]);
                        high_byte_write_strobe_n_o <= ~(half | addr[0]);
                     end
                  end else begin
                     static_output_enable_n_o <= 1'b0;
                  end
                  state <= ST_STROBE;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            ST_STROBE: begin
               if (cnt != 4'h0) begin
                  cnt <= cnt - 4'h1;
               end else if (external_wait_n_i) begin
                  static_output_enable_n_o   <= 1'b1;
                  low_byte_write_strobe_n_o  <= 1'b1;
                  high_byte_write_strobe_n_o <= 1'b1;
                  if (!wr) begin
                     if (wide && half) begin
                        resp_rdata_o <= static_data_bus_i;
                     end else if (wide) begin
                        resp_rdata_o <= {8'h00, addr[0] ? static_data_bus_i[15:8] : static_data_bus_i[7:0]};
                     end else if (beat) begin
                        resp_rdata_o[15:8] <= static_data_bus_i[7:0];
                     end else begin
                        resp_rdata_o <= {8'h00, static_data_bus_i[7:0]};
                     end
                  end
                  cnt   <= hold_len;
                  state <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (cnt != 4'h0) begin
                  cnt <= cnt - 4'h1;
               end else if (half && !wide && !beat) begin
                  // Second byte of a halfword; the chip select stays low across both beats.
                  beat              <= 1'b1;
                  ext_addr_o        <= pin_addr(addr, is_io, wide, 1'b1);
                  static_data_bus_o <= beat_data(wdata, half, wide, 1'b1);
                  state             <= ST_LOAD;
               end else begin
                  memory_bank_select_n_o <= 2'h3;
                  io_bank_select_n_o     <= 3'h7;
                  static_data_bus_oe_o   <= 1'b0;
                  resp_valid_o           <= 1'b1;
                  resp_error_o           <= 1'b0;
                  req_ready_o            <= 1'b1;
                  state                  <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// file: testbench/smc_static_ctrl_properties.sv
`timescale 1ns/100ps
module smc_static_ctrl_props #(
   parameter AW = 26
) (
   input  logic          sys_clk_i,
   input  logic          sys_rst_i,
   input  logic          ce_i,
   input  logic          req_valid_i,
   input  logic [AW-1:0] req_addr_i,
   input  logic          req_ready_o,
   input  logic          resp_valid_o,
   input  logic          resp_error_o,
   input  logic          nand_bus_busy_i,
   input  logic          watchdog_reset_req_i,
   input  logic          watchdog_reset_out_o,
   input  logic [1:0]    memory_bank_select_n_o,
   input  logic [2:0]    io_bank_select_n_o,
   input  logic          static_output_enable_n_o,
   input  logic          static_output_enable_n_oe_o,
   input  logic          low_byte_write_strobe_n_o,
   input  logic          high_byte_write_strobe_n_o,
   input  logic          external_wait_n_i,
   input  logic          static_data_bus_oe_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire [4:0] sel_n = {memory_bank_select_n_o, io_bank_select_n_o};
   wire       wr_n  = low_byte_write_strobe_n_o && high_byte_write_strobe_n_o;
   sequence s_take;
      ce_i && req_valid_i && req_ready_o && !nand_bus_busy_i;
   endsequence
   sequence s_unmapped;
      s_take ##0 (req_addr_i[25] && req_addr_i[15:14] == 2'h3);
   endsequence
   sequence s_err_done;
      resp_valid_o && resp_error_o && sel_n == 5'h1f;
   endsequence
   AST_SEL_ONE: assert property ($countones(~sel_n) <= 1)
      else $error("more than one select low");
   AST_IDLE: assert property (req_ready_o |-> sel_n == 5'h1f && static_output_enable_n_o && wr_n)
      else $error("pins active while idle");
   AST_OE_READ: assert property (!static_output_enable_n_o |-> wr_n && sel_n != 5'h1f)
      else $error("output enable outside a read");
   AST_WR_STRB: assert property (!wr_n |-> static_data_bus_oe_o && sel_n != 5'h1f)
      else $error("write strobe without driven data");
   AST_BUS_OWN: assert property (static_data_bus_oe_o |-> static_output_enable_n_o)
      else $error("bus driven during a read");
   AST_NAND: assert property (req_valid_i && req_ready_o && nand_bus_busy_i |=> req_ready_o && sel_n == 5'h1f)
      else $error("request taken while bus busy");
   AST_WAIT: assert property (!static_output_enable_n_o && !external_wait_n_i && ce_i |=> !static_output_enable_n_o)
      else $error("strobe ended during wait");
   AST_UNMAPPED: assert property (s_unmapped |=> s_err_done)
      else $error("unmapped bank not refused");
   AST_WDOG: assert property ($rose(watchdog_reset_req_i) && static_output_enable_n_oe_o && ce_i |=> $changed(watchdog_reset_out_o))
      else $error("watchdog output did not follow");
endmodule

bind smc_static_ctrl smc_static_ctrl_props #(.AW(AW)) u_props (.sys_clk_i, .sys_rst_i, .ce_i, .req_valid_i,
   .req_addr_i, .req_ready_o, .resp_valid_o, .resp_error_o, .nand_bus_busy_i, .watchdog_reset_req_i,
   .watchdog_reset_out_o, .memory_bank_select_n_o, .io_bank_select_n_o, .static_output_enable_n_o,
   .static_output_enable_n_oe_o, .low_byte_write_strobe_n_o, .high_byte_write_strobe_n_o, .external_wait_n_i,
   .static_data_bus_oe_o);

// file: testbench/smc_ext_dev.sv
`timescale 1ns/100ps
module smc_ext_dev (
   input  logic        sys_clk_i,
   input  logic [1:0]  mem_sel_n_i,
   input  logic [2:0]  io_sel_n_i,
   input  logic        oe_n_i,
   input  logic        lo_strb_n_i,
   input  logic        hi_strb_n_i,
   input  logic [5:0]  addr_i,
   input  logic [15:0] ctl_data_i,
   input  logic        ctl_oe_i,
   input  logic [3:0]  slow_i,
   output logic        wait_n_o,
   output logic [15:0] bus_o
);
   logic [15:0] mem [0:4][0:63];
   logic [3:0]  cnt = 4'h0;
   logic [2:0]  bank;
   wire         strobing = !oe_n_i || !lo_strb_n_i || !hi_strb_n_i;
   wire         selected = !(&{io_sel_n_i, mem_sel_n_i});
   initial for (int b = 0; b < 5; b++) for (int a = 0; a < 64; a++) mem[b][a] = 16'h0000;
   always_comb
      casez ({io_sel_n_i, mem_sel_n_i})
         5'b????0: bank = 3'h0;
         5'b???01: bank = 3'h1;
         5'b??011: bank = 3'h2;
         5'b?0111: bank = 3'h3;
         default:  bank = 3'h4;
      endcase
   // Writes are sampled on the falling clock edge, half a cycle after the pins change, so strobe and select edges landing together do no harm.
   // The pin address is used exactly as wired.
   always @(negedge sys_clk_i) begin
      if (selected && !lo_strb_n_i) mem[bank][addr_i][7:0] <= bus_o[7:0];
      if (selected && !hi_strb_n_i) mem[bank][addr_i][15:8] <= bus_o[15:8];
   end
   always @(posedge sys_clk_i)
      cnt <= !strobing ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
   assign wait_n_o = !(strobing && cnt < slow_i);
   // A released bus floats to the pull-up level.
   assign bus_o = ctl_oe_i ? ctl_data_i : (selected && !oe_n_i ? mem[bank][addr_i] : 16'hffff);
endmodule

// file: testbench/smc_static_ctrl_tb.sv
`timescale 1ns/100ps
`include "smc_defs.vh"
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin failures++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, x); end end
module smc_static_ctrl_tb;
   logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0;
   logic req_half_i = 1'b0, cfg_write_i = 1'b0, boot_wide_strap_i = 1'b1, nand_bus_busy_i = 1'b0;
   logic                       watchdog_reset_req_i = 1'b0, strap_pin = 1'b1;
   logic [25:0]                req_addr_i = 26'h0000000, ext_addr_o, pa_seen;
   logic [15:0]                req_wdata_i = 16'h0000, resp_rdata_o, static_data_bus_o;
   logic [`SMC_BANK_IDX_W-1:0] cfg_bank_i = 3'h0;
   logic [`SMC_CFG_W-1:0]      cfg_data_i = 13'h0000;
   logic [1:0]                 memory_bank_select_n_o;
   logic [2:0]                 io_bank_select_n_o;
   logic [4:0]                 sel_seen;
   logic [3:0]                 slow = 4'h0;
   logic req_ready_o, resp_valid_o, resp_error_o, watchdog_reset_out_o, static_output_enable_n_o;
   logic static_output_enable_n_oe_o, low_byte_write_strobe_n_o, high_byte_write_strobe_n_o, static_data_bus_oe_o;
   wire         static_output_enable_n_i, external_wait_n_i;
   wire  [15:0] static_data_bus_i;
   int          failures = 0, checks_done = 0, dur, dur_f;
   assign static_output_enable_n_i = static_output_enable_n_oe_o ? static_output_enable_n_o : strap_pin;
   smc_static_ctrl dut (.sys_clk_i, .sys_rst_i, .ce_i, .req_valid_i, .req_write_i, .req_half_i, .req_addr_i,
      .req_wdata_i, .req_ready_o, .resp_valid_o, .resp_error_o, .resp_rdata_o, .cfg_write_i, .cfg_bank_i,
      .cfg_data_i, .boot_wide_strap_i, .nand_bus_busy_i, .watchdog_reset_req_i, .watchdog_reset_out_o,
      .ext_addr_o, .memory_bank_select_n_o, .io_bank_select_n_o, .static_output_enable_n_i,
      .static_output_enable_n_o, .static_output_enable_n_oe_o, .low_byte_write_strobe_n_o,
      .high_byte_write_strobe_n_o, .external_wait_n_i, .static_data_bus_i, .static_data_bus_o, .static_data_bus_oe_o);
   smc_ext_dev u_dev (.sys_clk_i, .mem_sel_n_i(memory_bank_select_n_o), .io_sel_n_i(io_bank_select_n_o),
      .oe_n_i(static_output_enable_n_o), .lo_strb_n_i(low_byte_write_strobe_n_o),
      .hi_strb_n_i(high_byte_write_strobe_n_o), .addr_i(ext_addr_o[5:0]), .ctl_data_i(static_data_bus_o),
      .ctl_oe_i(static_data_bus_oe_o), .slow_i(slow), .wait_n_o(external_wait_n_i), .bus_o(static_data_bus_i));
   initial forever #12.5 sys_clk_i = ~sys_clk_i;
   always @(negedge sys_clk_i) if (!(&{memory_bank_select_n_o, io_bank_select_n_o})) begin
      sel_seen <= {memory_bank_select_n_o, io_bank_select_n_o};
      pa_seen <= ext_addr_o;
   end
   task automatic stop_test();
      $display("mismatches %0d, comparisons %0d", failures, checks_done);
      if (failures == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cfg(input logic [2:0] b, input logic [12:0] d);
      {cfg_bank_i, cfg_data_i, cfg_write_i} = {b, d, 1'b1};
      @(negedge sys_clk_i);
      cfg_write_i = 1'b0;
      @(negedge sys_clk_i);
   endtask
   // Holds the request until it is taken; a lost response ends the run rather than hanging it.
   task automatic acc(input logic w, h, input logic [25:0] a, input logic [15:0] d);
      int n;
      {req_write_i, req_half_i, req_addr_i, req_wdata_i, req_valid_i} = {w, h, a, d, 1'b1};
      for (n = 0; n < 99 && (req_ready_o !== 1'b1 || nand_bus_busy_i); n++) @(negedge sys_clk_i);
      @(negedge sys_clk_i);
      req_valid_i = 1'b0;
      for (dur = 1; dur < 999 && resp_valid_o !== 1'b1; dur++) @(negedge sys_clk_i);
      if (n >= 99 || dur >= 999) begin failures++; stop_test(); end
   endtask
   task automatic rd(input logic h, input logic [25:0] a, input logic [15:0] x);
      acc(1'b0, h, a, 16'h0000);
      `CHK(resp_rdata_o, x)
   endtask
   initial begin
      logic [25:0] a;
      repeat (4) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      `CHK({req_ready_o, sel_n_all(), static_output_enable_n_o}, 7'h7f)
      `CHK(static_output_enable_n_oe_o, 1'b1)
      `CHK(watchdog_reset_out_o, 1'b1)
      watchdog_reset_req_i = 1'b1;
      @(negedge sys_clk_i);
      `CHK(watchdog_reset_out_o, 1'b0)
      acc(1'b1, 1'b1, 26'h0000004, 16'ha55a);
      rd(1'b1, 26'h0000004, 16'ha55a);
      `CHK(pa_seen[13:0], 14'h0002)
      `CHK(sel_seen, 5'h17)
      acc(1'b1, 1'b0, 26'h0000007, 16'h003c);
      rd(1'b1, 26'h0000006, 16'h3c00);
      cfg(3'h1, 13'h0000);
      acc(1'b1, 1'b1, 26'h1000010, 16'hbeef);
      `CHK(pa_seen[13:0], 14'h0011)
      `CHK(sel_seen, 5'h0f)
      rd(1'b1, 26'h1000010, 16'hbeef);
      rd(1'b0, 26'h1000011, 16'h00be);
      dur_f = dur;
      slow = 4'h6;
      rd(1'b0, 26'h1000011, 16'h00be);
      `CHK(dur > dur_f, 1'b1)
      slow = 4'h0;
      for (int k = 0; k < 3; k++) begin
         a = 26'h2000008 | (26'h0004000 * k);
         cfg(3'h2 + k[2:0], k == 2 ? 13'h0120 : 13'h1120);
         acc(1'b1, 1'b1, a, 16'h1234 + k[15:0]);
         `CHK(pa_seen[13:0], k == 2 ? 14'h0009 : 14'h0008)
         `CHK(sel_seen, {2'b11, ~(3'h1 << k)})
         rd(1'b1, a, 16'h1234 + k[15:0]);
      end
      acc(1'b0, 1'b0, 26'h200c000, 16'h0000);
      `CHK(resp_error_o, 1'b1)
      // The refused request was dropped on this edge, so let one clock pass before raising it again.
      @(negedge sys_clk_i);
      nand_bus_busy_i = 1'b1;
      {req_write_i, req_half_i, req_addr_i, req_valid_i} = {2'b01, 26'h0000004, 1'b1};
      repeat (5) @(negedge sys_clk_i);
      `CHK({req_ready_o, memory_bank_select_n_o}, 3'h7)
      nand_bus_busy_i = 1'b0;
      rd(1'b1, 26'h0000004, 16'ha55a);
      ce_i = 1'b0;
      watchdog_reset_req_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      `CHK(watchdog_reset_out_o, 1'b0)
      ce_i = 1'b1;
      @(negedge sys_clk_i);
      `CHK(watchdog_reset_out_o, 1'b1)
      // A second reset with the strap pulled low must turn the watchdog output active high.
      strap_pin = 1'b0;
      watchdog_reset_req_i = 1'b1;
      sys_rst_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      `CHK(watchdog_reset_out_o, 1'b1)
      `CHK({req_ready_o, sel_n_all(), static_output_enable_n_o}, 7'h7f)
      stop_test();
   end
   function automatic logic [4:0] sel_n_all();
      return {memory_bank_select_n_o, io_bank_select_n_o};
   endfunction
endmodule
